// File: dmr_core.sv
// Summary of operation
// R1: Burst lengths 2, 4, 8 work with sequential and interleaved order.
// R2: Each READ or WRITE accesses no more columns than the burst length.
// R3: Burst stays in aligned block of burst length and wraps at boundary.
// R4: Column bits above burst-length bits select block, low bits start.
// R5: One burst length setting governs reads and writes alike.
// R6: Burst order bit chooses sequential or interleaved order.
// R7: Sequential access is start plus k modulo burst length.
// R8: Interleaved access low bits are start low bits XOR k.
// R9: Read latency programmable to two or two and a half clocks.
// R10: READ at edge n gives first data at n plus m; half on falling. Code: first read beat at edge n plus 3 for both latencies.
// R11: Controller avoids reserved burst length and latency codes.
// R12: Controller picks a latency allowed at its clock frequency.
// R13: Load with bits 7 to 12 zero selects normal operation.
// R14: Load with bit 8 set, others zero, starts a DLL reset.
// R15: Controller should follow a DLL reset load with a normal load.
// R16: Controller writes only normal or DLL reset operating codes.
// R17: Bank 01 load writes extended register: DLL enable, drive strength.
// R18: After DLL enable, controller resets DLL through base register.
// R19: Controller loads extended register only when idle, then waits.
// R20: Controller keeps DLL enabled for normal operation.
// R21: Self refresh exit enables DLL without any register load.
// R22: After DLL enable, at least 200 cycles pass before a READ.
// R23: Bits 0-2 length, 3 order, 4-6 latency, 7-12 operating mode.
// R24: Bank 00 load targets base register; DLL reset bit self-clears.
// R25: Address bits 0-12 are opcode; other bank codes are reserved.
// R26: Field codes follow the common DDR mode register encoding.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module dmr_core
    import dmr_pkg::*;
#(
    parameter int COL_W     = 13,
    parameter int LOCK_WAIT = DLL_LOCK_CYCLES
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire dmr_req_type  i_req,
    input  wire logic         i_sr_exit,
    output dmr_beat_type      o_beat,
    output logic              o_dll_locked,
    output logic              o_reserved_op,
    input  wire logic [3:0]   i_avs_address,
    input  wire logic         i_avs_read,
    input  wire logic         i_avs_write,
    input  wire logic [31:0]  i_avs_writedata,
    input  wire logic [3:0]   i_avs_byteenable,
    output logic [31:0]       o_avs_readdata,
    output logic              o_avs_waitrequest
);

    // Column slicing needs the eight-beat offset bits; the lock counter is only 16 bits wide
    if (COL_W < 4 || COL_W > 13 || LOCK_WAIT < 1 || LOCK_WAIT > 65535) begin : g_param_check
        $error("dmr_core: unsupported parameter");
    end

    // Burst length from code; reserved codes fall back to 8
    function automatic logic [3:0] bl_len(input logic [2:0] code);                  // R26
        case (code)
            BL_CODE_2: bl_len = 4'h2;
            BL_CODE_4: bl_len = 4'h4;
            default:   bl_len = 4'h8;
        endcase
    endfunction : bl_len

    function automatic logic [2:0] bl_mask(input logic [2:0] code);
        case (code)
            BL_CODE_2: bl_mask = 3'h1;
            BL_CODE_4: bl_mask = 3'h3;
            default:   bl_mask = 3'h7;
        endcase
    endfunction : bl_mask

    // Operating mode decode, shared by the load path and the reserved flag
    function automatic logic op_is_normal(input logic [12:0] opcode);
        op_is_normal = (opcode[MR_OP_MSB:MR_OP_LSB] == OP_NORMAL);
    endfunction : op_is_normal

    function automatic logic op_is_dll_rst(input logic [12:0] opcode);
        op_is_dll_rst = (opcode[MR_OP_MSB:MR_OP_LSB] == OP_DLL_RST);
    endfunction : op_is_dll_rst

    logic [12:0]        mr_q, mr_d;
    logic [12:0]        emr_q, emr_d;
    logic [15:0]        lock_q, lock_d;
    logic               dllrst_q, dllrst_d;
    logic               resop_q, resop_d;
    dmr_state_type      st_q, st_d;
    logic [COL_W-1:0]   start_q, start_d;
    logic [2:0]         k_q, k_d;
    logic [1:0]         wcnt_q, wcnt_d;
    logic               rd_q, rd_d;
    dmr_beat_type       beat_q, beat_d;
    logic [31:0]        rdata_q, rdata_d;
    logic               ack_q, ack_d;

    logic [2:0]         mask;
    logic [3:0]         blen;
    logic [2:0]         low;
    logic               dll_en;
    logic               is_cl25;
    logic               lmr;
    logic               avs_req;

    assign mask    = bl_mask(mr_q[MR_BL_MSB:MR_BL_LSB]);                         // R5 R23
    assign blen    = bl_len(mr_q[MR_BL_MSB:MR_BL_LSB]);
    assign dll_en  = ~emr_q[EMR_DLL_DIS];
    assign is_cl25 = (mr_q[MR_CL_MSB:MR_CL_LSB] == CL_CODE_25);                  // R9
    assign lmr     = (i_req.cmd == CMD_LMR);
    assign avs_req = i_avs_read | i_avs_write;

    // Column order within the block
    always_comb begin
        low = 3'h0;
        if (mr_q[MR_BT_BIT]) begin                                               // R6
            low = (start_q[2:0] ^ k_q) & mask;                                   // R8
        end else begin
            low = (start_q[2:0] + k_q) & mask;                                   // R7
        end
    end

    // Mode registers, from the command port or the register bus
    always_comb begin
        mr_d     = mr_q;
        emr_d    = emr_q;
        lock_d   = lock_q;
        dllrst_d = 1'b0;                                                         // R24
        resop_d  = resop_q;
        if (lock_q != 16'h0) begin
            lock_d = lock_q - 16'h1;
        end
        if (lmr && i_req.bank == BA_MR) begin                                    // R24 R25
            mr_d = i_req.addr;
            mr_d[MR_DLLRST] = 1'b0;
            resop_d = !op_is_normal(i_req.addr) && !op_is_dll_rst(i_req.addr);   // R13 R16
            if (op_is_dll_rst(i_req.addr)) begin                                 // R14
                dllrst_d = 1'b1;
                lock_d   = LOCK_WAIT[15:0];                                      // R22
            end
        end else if (lmr && i_req.bank == BA_EMR) begin                          // R17
            emr_d = i_req.addr;
            if (emr_q[EMR_DLL_DIS] && !i_req.addr[EMR_DLL_DIS]) begin
                lock_d = LOCK_WAIT[15:0];                                        // R22
            end
        end else if (i_avs_write && ack_q && i_avs_byteenable[0]) begin
            // Write lands in the answer cycle, the edge the master sees waitrequest low
            if (i_avs_address == REG_MODE) begin
                mr_d = i_avs_writedata[12:0];
                mr_d[MR_DLLRST] = 1'b0;
            end else if (i_avs_address == REG_EXT_MODE) begin
                emr_d = i_avs_writedata[12:0];
                if (emr_q[EMR_DLL_DIS] && !i_avs_writedata[EMR_DLL_DIS]) begin
                    lock_d = LOCK_WAIT[15:0];                                    // R22
                end
            end
        end
        if (i_sr_exit) begin                                                     // R21
            emr_d[EMR_DLL_DIS] = 1'b0;
            lock_d = LOCK_WAIT[15:0];
        end
    end

    // Burst engine: one beat per clock; the half-clock read latency rides in the beat half flag
    always_comb begin
        st_d    = st_q;
        start_d = start_q;
        k_d     = k_q;
        wcnt_d  = wcnt_q;
        rd_d    = rd_q;
        beat_d  = '0;
        if ((i_req.cmd == CMD_READ) || (i_req.cmd == CMD_WRITE)) begin
            start_d = i_req.addr[COL_W-1:0];
            k_d     = 3'h0;
            rd_d    = (i_req.cmd == CMD_READ);
            wcnt_d  = (i_req.cmd == CMD_READ) ? 2'h1 : 2'h0;                     // R10
            st_d    = (i_req.cmd == CMD_READ) ? ST_WAIT : ST_BURST;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    st_d = ST_IDLE;
                end
                ST_WAIT: begin
                    if (wcnt_q == 2'h0) begin
                        st_d = ST_BURST;
                    end else begin
                        wcnt_d = wcnt_q - 2'h1;
                    end
                end
                ST_BURST: begin
                    beat_d.valid   = 1'b1;
                    beat_d.is_read = rd_q;
                    beat_d.half    = rd_q & is_cl25;                             // R10
                    beat_d.col     = 13'(start_q);                               // R4
                    beat_d.col[2:0] = (start_q[2:0] & ~mask) | low;              // R3
                    if ({1'b0, k_q} + 4'h1 >= blen) begin                        // R2 R1
                        st_d = ST_IDLE;
                    end else begin
                        k_d = k_q + 3'h1;
                    end
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    // Avalon slave: one wait cycle then answer
    always_comb begin
        ack_d   = avs_req & ~ack_q;
        rdata_d = rdata_q;
        if (i_avs_read && !ack_q) begin
            case (i_avs_address)
                REG_MODE:     rdata_d = {19'h0, mr_q};
                REG_EXT_MODE: rdata_d = {19'h0, emr_q};
                REG_STATUS:   rdata_d = {28'h0, rd_q & (st_q != ST_IDLE), st_q != ST_IDLE,
                                         dll_en, dll_en && lock_q == 16'h0};
                default:      rdata_d = 32'h0;
            endcase
        end
    end

    // Mode register group
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mr_q     <= MR_RESET;
            emr_q    <= EMR_RESET;
            lock_q   <= 16'h0;
            dllrst_q <= 1'b0;
            resop_q  <= 1'b0;
        end else begin
            mr_q     <= mr_d;
            emr_q    <= emr_d;
            lock_q   <= lock_d;
            dllrst_q <= dllrst_d;
            resop_q  <= resop_d;
        end
    end

    // Burst group
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_q     <= ST_IDLE;
            start_q  <= '0;
            k_q      <= 3'h0;
            wcnt_q   <= 2'h0;
            rd_q     <= 1'b0;
            beat_q   <= '0;
        end else begin
            st_q     <= st_d;
            start_q  <= start_d;
            k_q      <= k_d;
            wcnt_q   <= wcnt_d;
            rd_q     <= rd_d;
            beat_q   <= beat_d;
        end
    end

    // Register bus group
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_q  <= 32'h0;
            ack_q    <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            ack_q    <= ack_d;
        end
    end

    assign o_beat            = beat_q;
    assign o_dll_locked      = dll_en & (lock_q == 16'h0) & ~dllrst_q;
    assign o_reserved_op     = resop_q;
    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = avs_req & ~ack_q;

endmodule : dmr_core
`default_nettype wire

// File: dmr_pkg.sv
package dmr_pkg;

    // Mode register field layout
    localparam int MR_BL_LSB   = 0;
    localparam int MR_BL_MSB   = 2;
    localparam int MR_BT_BIT   = 3;
    localparam int MR_CL_LSB   = 4;
    localparam int MR_CL_MSB   = 6;
    localparam int MR_OP_LSB   = 7;
    localparam int MR_OP_MSB   = 12;
    localparam int MR_DLLRST   = 8;

    // Burst length codes
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;

    // CAS latency codes
    localparam logic [2:0] CL_CODE_2  = 3'h2;
    localparam logic [2:0] CL_CODE_25 = 3'h6;

    // Operating mode codes (A12..A7)
    localparam logic [5:0] OP_NORMAL  = 6'h00;
    localparam logic [5:0] OP_DLL_RST = 6'h02;

    // Extended mode register bits
    localparam int EMR_DLL_DIS = 0;
    localparam int EMR_DRV_RED = 1;

    // Bank select codes {BA1,BA0}
    localparam logic [1:0] BA_MR  = 2'h0;
    localparam logic [1:0] BA_EMR = 2'h1;

    // Reset values
    localparam logic [12:0] MR_RESET  = 13'h0032;
    localparam logic [12:0] EMR_RESET = 13'h0000;

    // DLL lock wait in clock cycles
    localparam int DLL_LOCK_CYCLES = 200;

    // Avalon register map
    localparam logic [3:0] REG_MODE     = 4'h0;
    localparam logic [3:0] REG_EXT_MODE = 4'h4;
    localparam logic [3:0] REG_STATUS   = 4'h8;

    // Status bit positions
    localparam int ST_DLL_LOCKED = 0;
    localparam int ST_DLL_EN     = 1;
    localparam int ST_BURST_ACT  = 2;
    localparam int ST_READ_PEND  = 3;

    typedef enum logic [1:0] {
        CMD_NOP   = 2'b00,
        CMD_READ  = 2'b01,
        CMD_WRITE = 2'b10,
        CMD_LMR   = 2'b11
    } dmr_cmd_type;

    typedef struct packed {
        dmr_cmd_type cmd;
        logic [1:0]  bank;
        logic [12:0] addr;
    } dmr_req_type;

    typedef struct packed {
        logic        valid;
        logic        is_read;
        logic        half;
        logic [12:0] col;
    } dmr_beat_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_BURST = 2'b10
    } dmr_state_type;

endpackage : dmr_pkg

// File: dmr_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dmr_properties
    import dmr_pkg::*;
#(
    parameter int LOCK_WAIT = DLL_LOCK_CYCLES
) (
    input wire logic         i_clk,
    input wire logic         i_rstn,
    input wire dmr_req_type  i_req,
    input wire logic         i_sr_exit,
    input wire dmr_beat_type o_beat,
    input wire logic         o_dll_locked,
    input wire logic [3:0]   i_avs_address,
    input wire logic         i_avs_read,
    input wire logic         i_avs_write,
    input wire logic [31:0]  i_avs_writedata,
    input wire logic [3:0]   i_avs_byteenable,
    input wire logic [31:0]  o_avs_readdata,
    input wire logic         o_avs_waitrequest
);
    localparam int RELOCK_MAX = LOCK_WAIT + 4;
    logic [3:0] quiet_q, quiet_d;
    logic       cl25_q, cl25_d;
    int         low_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Late in a quiet stretch two beats can only come from one burst
    always_comb begin
        quiet_d = (i_req.cmd != CMD_NOP) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
        cl25_d  = cl25_q;
        if (i_req.cmd == CMD_LMR && i_req.bank == BA_MR)
            cl25_d = i_req.addr[MR_CL_MSB:MR_CL_LSB] == CL_CODE_25;
        else if (!(i_req.cmd == CMD_LMR && i_req.bank == BA_EMR) && i_avs_write && !o_avs_waitrequest &&
                 i_avs_byteenable[0] && i_avs_address == REG_MODE)
            cl25_d = i_avs_writedata[MR_CL_MSB:MR_CL_LSB] == CL_CODE_25;
    end
    // Counts how long the lock flag has been low, saturating at the wait length
    always_ff @(posedge i_clk) begin
        quiet_q <= i_rstn ? quiet_d : 4'h0;
        cl25_q  <= i_rstn ? cl25_d : 1'h0;
        low_q   <= (!i_rstn || o_dll_locked) ? 0 : low_q + int'(low_q < LOCK_WAIT);
    end
    sequence rd_alone;
        i_req.cmd == CMD_READ ##1 (i_req.cmd == CMD_NOP) [*3];
    endsequence
    sequence wr_alone;
        i_req.cmd == CMD_WRITE ##1 i_req.cmd == CMD_NOP;
    endsequence
    read_latency_a: assert property (rd_alone |=> o_beat.valid && o_beat.is_read && o_beat.col == $past(i_req.addr, 4))
        else $error("read beat not at latency");
    write_start_a: assert property (wr_alone |=> o_beat.valid && !o_beat.is_read && o_beat.col == $past(i_req.addr, 2))
        else $error("write beat not at start column");
    block_keep_a: assert property (o_beat.valid && $past(o_beat.valid) && quiet_q >= 4'h3 |-> $stable(o_beat.col[12:3]))
        else $error("burst left its block");
    half_edge_a: assert property (o_beat.valid && o_beat.is_read && quiet_q >= 4'h2 |-> o_beat.half == $past(cl25_q))
        else $error("half cycle flag wrong");
    mode_selfclr_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == REG_MODE
        |-> !o_avs_readdata[MR_DLLRST]) else $error("dll reset bit stored");
    dll_off_a: assert property (i_req.cmd == CMD_LMR && i_req.bank == BA_EMR && i_req.addr[EMR_DLL_DIS]
        |=> !o_dll_locked [*2]) else $error("locked with dll disabled");
    lock_wait_a: assert property ($rose(o_dll_locked) |-> low_q >= LOCK_WAIT)
        else $error("lock too early");
    srx_relock_a: assert property (i_sr_exit |=> !o_dll_locked ##[1:RELOCK_MAX] o_dll_locked)
        else $error("no relock after self refresh exit");
endmodule : dmr_properties
bind dmr_core dmr_properties #(.LOCK_WAIT(LOCK_WAIT)) u_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req),
    .i_sr_exit(i_sr_exit), .o_beat(o_beat), .o_dll_locked(o_dll_locked), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire

// File: dmr_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module dmr_ctrl_model
    import dmr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_dll_locked,
    output var dmr_req_type  o_req,
    output var logic         o_sr_exit
);
    initial begin
        o_req = '0;
        o_sr_exit = 1'h0;
    end
    // Callers pass only defined codes, bar one load to reserved bank 2, and load registers between bursts
    task automatic issue(input dmr_cmd_type c, input logic [1:0] b, input logic [12:0] a);
        int n;
        n = 0;
        while (c == CMD_READ && i_dll_locked !== 1'h1 && n < 400) begin
            n++;
            @(posedge i_clk);
        end
        @(posedge i_clk);
        o_req <= '{cmd: c, bank: b, addr: a};
        @(posedge i_clk);
        o_req <= '{cmd: CMD_NOP, bank: ~b, addr: ~a};
    endtask : issue
    task automatic sr_exit();
        @(posedge i_clk);
        o_sr_exit <= 1'h1;
        @(posedge i_clk);
        o_sr_exit <= 1'h0;
    endtask : sr_exit
endmodule : dmr_ctrl_model
`default_nettype wire

// File: test_ddr_mode_register_burst_logic.sv
`timescale 1ns/1ns
`default_nettype none
module test_ddr_mode_register_burst_logic
    import dmr_pkg::*;
;
    localparam int LW = 8;
    logic         clk, rstn, av_rd, av_wr, wait_rq, locked, sr_exit, resop;
    logic [3:0]   av_addr, av_be;
    logic [31:0]  av_wd, rdata;
    dmr_req_type  req;
    dmr_beat_type beat;
    int           fails, checks_done, cycles;
    dmr_core #(.LOCK_WAIT(LW)) u_dut (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_sr_exit(sr_exit),
        .o_beat(beat), .o_dll_locked(locked), .o_reserved_op(resop), .i_avs_address(av_addr), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(av_be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_rq));
    dmr_ctrl_model u_ctrl (.i_clk(clk), .i_dll_locked(locked), .o_req(req), .o_sr_exit(sr_exit));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        av_wr <= wr;
        av_rd <= ~wr;
        av_addr <= a;
        av_wd <= d;
        @(posedge clk);
        while (wait_rq !== 1'h0)
            @(posedge clk);
        q = rdata;
        av_wr <= 1'h0;
        av_rd <= 1'h0;
        @(posedge clk);
    endtask : bus
    task automatic t_regs();
        logic [31:0] q;
        bus(1'h0, REG_MODE, 32'h0, q);
        chk("mode reset", 32'(MR_RESET), q);
        bus(1'h0, REG_EXT_MODE, 32'h0, q);
        chk("ext reset", 32'(EMR_RESET), q);
        bus(1'h1, REG_MODE, 32'h122, q);
        bus(1'h0, REG_MODE, 32'h0, q);
        chk("mode self clear", 32'h22, q);
        av_be <= 4'he;
        bus(1'h1, REG_MODE, 32'h1fff, q);
        av_be <= 4'hf;
        bus(1'h0, REG_MODE, 32'h0, q);
        chk("masked write", 32'h22, q);
        bus(1'h0, REG_STATUS, 32'h0, q);
        chk("status idle", 32'h3, q);
        bus(1'h1, 4'hc, 32'h1fff, q);
        bus(1'h0, 4'hc, 32'h0, q);
        chk("unmapped", 32'h0, q);
        u_ctrl.issue(CMD_LMR, 2'h2, 13'h33);
        bus(1'h0, REG_MODE, 32'h0, q);
        chk("reserved bank", 32'h22, q);
        $display("register test done");
    endtask : t_regs
    task automatic t_bursts();
        logic [12:0] st, col;
        int          bl;
        st = 13'h1f5;
        for (int i = 0; i < 12; i++) begin
            bl = 2 << (i / 4);
            u_ctrl.issue(CMD_LMR, BA_MR, {OP_NORMAL, i[1] ? CL_CODE_25 : CL_CODE_2, i[1], BL_CODE_2 + 3'(i / 4)});
            u_ctrl.issue(i[0] ? CMD_READ : CMD_WRITE, 2'h0, st);
            // Read beats trail the command by three edges, writes by one
            repeat (i[0] ? 3 : 1) @(posedge clk);
            for (int k = 0; k < bl; k++) begin
                @(negedge clk);
                col = (st & ~13'(bl - 1)) | (13'(i[1] ? (st ^ 13'(k)) : (st + 13'(k))) & 13'(bl - 1));
                chk("beat", 32'({1'h1, i[0], i[0] & i[1], col}), 32'(beat));
                @(posedge clk);
            end
            @(negedge clk);
            chk("burst end", 32'h0, 32'(beat.valid));
        end
        $display("burst test done");
    endtask : t_bursts
    task automatic t_dll();
        logic [31:0] q;
        int          n;
        u_ctrl.issue(CMD_LMR, BA_EMR, 13'h1);
        @(negedge clk);
        chk("dll off", 32'h0, 32'(locked));
        @(posedge clk);
        bus(1'h0, REG_EXT_MODE, 32'h0, q);
        chk("ext mode", 32'h1, q);
        u_ctrl.issue(CMD_LMR, BA_EMR, 13'h0);
        u_ctrl.issue(CMD_LMR, BA_MR, {OP_DLL_RST, CL_CODE_2, 1'h0, BL_CODE_4});
        @(negedge clk);
        chk("dll reset lock", 32'h0, 32'(locked));
        chk("reserved op", 32'h0, 32'(resop));
        u_ctrl.issue(CMD_LMR, BA_MR, {OP_NORMAL, CL_CODE_2, 1'h0, BL_CODE_4});
        u_ctrl.sr_exit();
        n = 0;
        @(negedge clk);
        while (locked !== 1'h1 && n < 40) begin
            n++;
            @(negedge clk);
        end
        chk("relock cycles", 32'h1, 32'(n >= LW && n <= LW + 2));
        $display("dll test done");
    endtask : t_dll
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 3000) begin
                fails++;
                report_and_stop();
            end
        end
    end
    initial begin
        fails = 0;
        checks_done = 0;
        rstn = 1'h0;
        av_rd = 1'h0;
        av_wr = 1'h0;
        av_addr = 4'h0;
        av_wd = 32'h0;
        av_be = 4'hf;
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        t_regs();
        t_bursts();
        t_dll();
        report_and_stop();
    end
endmodule : test_ddr_mode_register_burst_logic
`default_nettype wire
